// ### verilog/rsds_pkg.sv
// Package: constants and types of the reset start-up sequencer
package rsds_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int POWERUP_EXT_NS = 600000;
    localparam int POWERUP_EXT_CYC = POWERUP_EXT_NS / CLK_PERIOD_NS;
    localparam int BOD_FILT_HI_NS = 9000;
    localparam int BOD_FILT_LO_NS = 21000;
    localparam int BOD_FILT_HI_CYC =
        (BOD_FILT_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOD_FILT_LO_CYC =
        (BOD_FILT_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Watchdog oscillator cycle counts of the real-time part
    localparam logic [16:0] RT_SHORT = 17'h0_0008;
    localparam logic [16:0] RT_SHORT_BOD = 17'h0_0020;
    localparam logic [16:0] RT_MED_LO = 17'h0_0400;
    localparam logic [16:0] RT_MED_HI = 17'h0_1000;
    localparam logic [16:0] RT_LONG_LO = 17'h0_4000;
    localparam logic [16:0] RT_LONG_HI = 17'h1_0000;

    // System clock counts of the clock-counting part
    localparam logic [16:0] CK_6 = 17'h0_0006;
    localparam logic [16:0] CK_1K = 17'h0_0400;
    localparam logic [16:0] CK_16K = 17'h0_4000;
    localparam logic [16:0] CK_32K = 17'h0_8000;

    // Start select codes
    localparam logic [3:0] SEL_DEFAULT = 4'h2;
    localparam logic [3:0] SEL_EXT_RC_BOD = 4'h7;
    localparam logic [3:0] SEL_LF_32K = 4'h8;
    localparam logic [3:0] SEL_LF_1K = 4'h9;
    localparam logic [3:0] SEL_XTAL_LONG = 4'hA;
    localparam logic [3:0] SEL_XTAL_MED = 4'hB;
    localparam logic [3:0] SEL_XTAL_SHORT = 4'hC;
    localparam logic [3:0] SEL_CER_LONG = 4'hD;
    localparam logic [3:0] SEL_CER_MED = 4'hE;
    localparam logic [3:0] SEL_CER_SHORT = 4'hF;
    localparam logic FUSE_PROGRAMMED = 1'b0;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_FUSE_OFF = 8'h00;
    localparam logic [7:0] REG_STATUS_OFF = 8'h04;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FUSE_SEL_LSB = 0;
    localparam int FUSE_BROWNOUT_ENABLE_FUSE_BIT = 4;
    localparam int FUSE_BODLVL_BIT = 5;
    localparam logic [5:0] FUSE_RESET = 6'h32;
    localparam int FUSE_W = 6;
    localparam int STATUS_W = 5;

    // Fuse field layout, bit 5 down to 0
    typedef struct packed {
        logic bod_level;
        logic bod_en;
        logic [3:0] start_sel;
    } rsds_fuse_t;

    // Status layout, bit 4 down to 0
    typedef struct packed {
        logic wake_active;
        logic powerup_pend;
        logic bod_trip;
        logic clk_en;
        logic core_rst;
    } rsds_status_t;

    typedef enum {
        ST_HOLD, ST_RT_WAIT, ST_PU_EXT, ST_CK_WAIT, ST_RUN, ST_SLEEP
    } rsds_state_t;
endpackage : rsds_pkg

// ### verilog/rsds_top.sv
// Reset merge and start-up delay sequencer with AXI4-Lite registers
//
// Function
// - Code 0111: short interval plus 6 clocks
// - Codes 1010-1100: long/medium/short plus 16K clocks
// - Codes 1101-1111: long/medium/short plus 1K clocks
// - Fuse bit one unprogrammed, zero programmed
// - Brown-out enabled lengthens short interval
// - First power-up adds about 0.6 ms
// - Wake from sleep: clock part only
// - Real-time part counts watchdog oscillator cycles
// - Level unprogrammed: 8, 32, 1K, 16K
// - Level programmed: 8, 32, 4K, 64K
// - Level fuse picks counts even without detection
// - Start select defaults to 0010
// - Power-on release waits the selected period
// - Low supply reasserts reset at once
// - Reset pin low forces reset without clock
// - Pin high again: run timer, then release
// - Enabled brown-out asserts reset once the persistence filter trips
// - Brown-out recovery uses same start-up delay
// - Level fuse selects 2.7 V or 4.0 V
// - Brown-out needs 9 or 21 us persistence
// - Core held in initial state, restarts at vector
`timescale 1ns/10ps

// Two-flop synchroniser for asynchronous levels
module rsds_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : rsds_sync

module rsds_top #(
    parameter int POWERUP_CYC = rsds_pkg::POWERUP_EXT_CYC
) (
    // Clock and bus reset
    input wire logic clk,
    input wire logic rst_n,
    // Supply monitors, reset pin and timing source
    input wire logic por_low,
    input wire logic reset_pin_n,
    input wire logic bod_low,
    input wire logic watchdog_oscillator,
    // Sleep controller, same clock domain
    input wire logic sleep_req,
    input wire logic wake_req,
    // Core side
    output logic core_rst_n,
    output logic core_clk_en,
    // Brown-out detector control
    output logic bod_enable,
    output logic bod_level_high,
    // AXI4-Lite write address and data
    input wire logic [rsds_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [rsds_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rsds_pkg::*;

    rsds_fuse_t fuse_r;
    rsds_status_t status;
    rsds_state_t state_r;
    rsds_state_t state_nxt;
    logic src_rst_n;
    logic por_rst_n;
    logic hold_meta_r;
    logic hold_ok_r;
    logic [1:0] async_s;
    logic wdog_s;
    logic bod_s;
    logic wdog_prev_r;
    logic wdog_rise;
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    logic [16:0] rt_sel;
    logic [16:0] ck_sel;
    logic [16:0] rt_tgt_r;
    logic [16:0] ck_tgt_r;
    logic [16:0] pu_tgt;
    logic [9:0] bod_cnt_r;
    logic [9:0] bod_tgt;
    logic bod_trip_r;
    logic bod_on;
    logic lvl_prog;
    logic powerup_r;
    logic wake_r;
    logic core_rst_n_r;
    logic core_clk_en_r;
    logic bod_enable_r;
    logic bod_level_high_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Reset pin and supply monitor merge asynchronously
    assign src_rst_n = rst_n & ~por_low & reset_pin_n;
    assign por_rst_n = rst_n & ~por_low;

    // Release is synchronised so no flop sees a runt edge
    always_ff @(posedge clk or negedge src_rst_n)
    begin
        if (!src_rst_n)
        begin
            hold_meta_r <= 1'b0;
            hold_ok_r <= 1'b0;
        end
        else
        begin
            hold_meta_r <= 1'b1;
            hold_ok_r <= hold_meta_r;
        end
    end

    // Watchdog oscillator and brown-out flag come from outside
    rsds_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({watchdog_oscillator, bod_low}),
        .q(async_s)
    );
    assign wdog_s = async_s[1];
    assign bod_s = async_s[0];

    // Edge of the synchronised oscillator paces the real-time part
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wdog_prev_r <= 1'b0;
        else
            wdog_prev_r <= wdog_s;
    end
    assign wdog_rise = wdog_s & ~wdog_prev_r;

    // Fuse decode: a stored zero means programmed
    assign bod_on = (fuse_r.bod_en == FUSE_PROGRAMMED);
    assign lvl_prog = (fuse_r.bod_level == FUSE_PROGRAMMED);

    // Real-time interval; level fuse rules even with detection off
    always_comb
    begin
        case (fuse_r.start_sel)
            4'h1, 4'h4, SEL_EXT_RC_BOD, SEL_XTAL_SHORT, SEL_CER_SHORT:
                rt_sel = bod_on ? RT_SHORT_BOD : RT_SHORT;
            4'h0, 4'h3, 4'h6, SEL_XTAL_MED, SEL_CER_MED:
                rt_sel = lvl_prog ? RT_MED_HI : RT_MED_LO;
            default:
                rt_sel = lvl_prog ? RT_LONG_HI : RT_LONG_LO;
        endcase
    end

    // Clock-counting part
    always_comb
    begin
        case (fuse_r.start_sel)
            SEL_LF_32K:
                ck_sel = CK_32K;
            SEL_LF_1K:
                ck_sel = CK_1K;
            SEL_XTAL_LONG, SEL_XTAL_MED, SEL_XTAL_SHORT:
                ck_sel = CK_16K;
            SEL_CER_LONG, SEL_CER_MED, SEL_CER_SHORT:
                ck_sel = CK_1K;
            default:
                ck_sel = CK_6;
        endcase
    end

    assign pu_tgt = 17'(POWERUP_CYC);

    // Persistence filter; the 4.0 V level reacts faster
    assign bod_tgt = lvl_prog ? 10'(BOD_FILT_HI_CYC)
                              : 10'(BOD_FILT_LO_CYC);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bod_cnt_r <= '0;
            bod_trip_r <= 1'b0;
        end
        else if (!(bod_on && bod_s))
        begin
            bod_cnt_r <= '0;  // Recovery or detector disabled
            bod_trip_r <= 1'b0;
        end
        else if (bod_cnt_r == bod_tgt - 10'h001)
            bod_trip_r <= 1'b1;
        else
            bod_cnt_r <= bod_cnt_r + 10'h001;
    end

    // Sequencer next state; any source sends it back to hold
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (bod_trip_r && state_r != ST_HOLD)
        begin
            state_nxt = ST_HOLD;
            cnt_nxt = '0;
        end
        else
        begin
            case (state_r)
                ST_HOLD:
                    if (hold_ok_r && !bod_trip_r)
                    begin
                        state_nxt = ST_RT_WAIT;
                        cnt_nxt = '0;
                    end
                ST_RT_WAIT:
                    if (wdog_rise)
                    begin
                        cnt_nxt = cnt_r + 17'h0_0001;
                        if (cnt_nxt == rt_tgt_r)
                        begin
                            state_nxt = powerup_r ? ST_PU_EXT : ST_CK_WAIT;
                            cnt_nxt = '0;
                        end
                    end
                ST_PU_EXT:
                begin
                    cnt_nxt = cnt_r + 17'h0_0001;
                    if (cnt_nxt >= pu_tgt)
                    begin
                        state_nxt = ST_CK_WAIT;
                        cnt_nxt = '0;
                    end
                end
                ST_CK_WAIT:
                begin
                    cnt_nxt = cnt_r + 17'h0_0001;
                    if (cnt_nxt == ck_tgt_r)
                    begin
                        state_nxt = ST_RUN;
                        cnt_nxt = '0;
                    end
                end
                ST_RUN:
                    if (sleep_req)
                        state_nxt = ST_SLEEP;
                ST_SLEEP:
                    if (wake_req)
                    begin
                        state_nxt = ST_CK_WAIT;
                        cnt_nxt = '0;
                    end
                default:
                begin
                    state_nxt = ST_HOLD;
                    cnt_nxt = '0;
                end
            endcase
        end
    end

    // State and counter restart at once on any merged source
    always_ff @(posedge clk or negedge src_rst_n)
    begin
        if (!src_rst_n)
        begin
            state_r <= ST_HOLD;
            cnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Targets frozen at the start so a fuse write cannot cut a delay
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rt_tgt_r <= RT_LONG_LO;
            ck_tgt_r <= CK_6;
        end
        else if (state_r == ST_HOLD)
        begin
            rt_tgt_r <= rt_sel;
            ck_tgt_r <= ck_sel;
        end
    end

    // Wake delay keeps the core out of reset, only the clock stops
    always_ff @(posedge clk or negedge src_rst_n)
    begin
        if (!src_rst_n)
            wake_r <= 1'b0;
        else if (state_r == ST_SLEEP && state_nxt == ST_CK_WAIT)
            wake_r <= 1'b1;
        else if (state_nxt != ST_CK_WAIT)
            wake_r <= 1'b0;
    end

    // Power-up extension pending until the first sequence uses it
    always_ff @(posedge clk or negedge por_rst_n)
    begin
        if (!por_rst_n)
            powerup_r <= 1'b1;
        else if (state_r == ST_PU_EXT && state_nxt == ST_CK_WAIT)
            powerup_r <= 1'b0;
    end

    // Core reset asserts asynchronously on a merged source, on the clock on brown-out; releases on the clock
    always_ff @(posedge clk or negedge src_rst_n)
    begin
        if (!src_rst_n)
        begin
            core_rst_n_r <= 1'b0;
            core_clk_en_r <= 1'b0;
        end
        else
        begin
            core_rst_n_r <= (state_nxt == ST_RUN)
                || (state_nxt == ST_SLEEP)
                || (state_nxt == ST_CK_WAIT && (wake_r
                    || state_r == ST_SLEEP));
            core_clk_en_r <= (state_nxt == ST_RUN);
        end
    end

    // Detector control follows the fuses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bod_enable_r <= 1'b0;
            bod_level_high_r <= 1'b0;
        end
        else
        begin
            bod_enable_r <= bod_on;
            bod_level_high_r <= lvl_prog;
        end
    end

    // Fuse image; start select writes take effect at the next sequence, detector bits at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fuse_r <= FUSE_RESET;
        else if (aw_held_r && w_held_r && !bvalid_r
                 && awaddr_r[ADDR_W-1:2] == REG_FUSE_OFF[ADDR_W-1:2]
                 && wstrb_r[0])
            fuse_r <= wdata_r[FUSE_W-1:0];
    end

    // Write address and data are taken in either order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end
        else if (aw_held_r && w_held_r && !bvalid_r)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    // Ready is a flop; it drops while an item is held
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid
                && s_axi_awready) && !bvalid_r;
            s_axi_wready <= !w_held_r && !(s_axi_wvalid
                && s_axi_wready) && !bvalid_r;
        end
    end

    // Write response once both halves are in
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (aw_held_r && w_held_r && !bvalid_r)
        begin
            bvalid_r <= 1'b1;
            if (awaddr_r[ADDR_W-1:2] == REG_FUSE_OFF[ADDR_W-1:2]
                || awaddr_r[ADDR_W-1:2] == REG_STATUS_OFF[ADDR_W-1:2])
                bresp_r <= RESP_OKAY;  // Status write is ignored
            else
                bresp_r <= RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // Status view of the sequencer
    assign status.wake_active = wake_r;
    assign status.powerup_pend = powerup_r;
    assign status.bod_trip = bod_trip_r;
    assign status.clk_en = core_clk_en_r;
    assign status.core_rst = ~core_rst_n_r;

    // Read channel: one cycle from address to data
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            if (s_axi_araddr[ADDR_W-1:2] == REG_FUSE_OFF[ADDR_W-1:2])
                rdata_r <= {26'h000_0000, fuse_r};
            else if (s_axi_araddr[ADDR_W-1:2]
                     == REG_STATUS_OFF[ADDR_W-1:2])
                rdata_r <= {27'h000_0000, status};
            else
            begin
                rdata_r <= '0;
                rresp_r <= RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Only one read in flight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_axi_arready <= 1'b0;
        else
            s_axi_arready <= !rvalid_r && !(s_axi_arvalid
                && s_axi_arready);
    end

    // Outputs straight from flops
    assign core_rst_n = core_rst_n_r;
    assign core_clk_en = core_clk_en_r;
    assign bod_enable = bod_enable_r;
    assign bod_level_high = bod_level_high_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule : rsds_top

// ### verif/rsds_top_monitor.sv
// Checker of the reset sequencer top-level ports
`timescale 1ns/10ps
module rsds_top_monitor
    import rsds_pkg::*;
#(
    parameter int POWERUP_CYC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sources
    input wire logic por_low,
    input wire logic reset_pin_n,
    input wire logic bod_low,
    // Core side and detector control
    input wire logic core_rst_n,
    input wire logic core_clk_en,
    input wire logic bod_enable,
    input wire logic bod_level_high,
    // Bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    int low_cnt;
    int lim;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Raw low-supply run length; margin covers synchroniser and trip flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt <= 0;
        else
            low_cnt <= bod_low ? low_cnt + 1 : 0;
    end
    assign lim = (bod_level_high ? BOD_FILT_HI_CYC : BOD_FILT_LO_CYC) + 8;
    a_clk_en_run: assert property (core_clk_en |-> core_rst_n)
        else $error("core clock enabled during reset");
    a_pin_reset: assert property (!reset_pin_n |-> !core_rst_n)
        else $error("pin low but core out of reset");
    a_por_reset: assert property (por_low |-> !core_rst_n)
        else $error("low supply but core out of reset");
    a_release_wait: assert property ($rose(core_rst_n) |->
        $past(reset_pin_n, 2) && !$past(por_low, 2))
        else $error("release too soon after a source");
    a_bod_trip: assert property (bod_enable && low_cnt > lim
        |-> !core_rst_n)
        else $error("brown-out did not reset the core");
    a_bod_filter: assert property ($fell(core_rst_n) && reset_pin_n
        && !por_low |-> low_cnt >= BOD_FILT_HI_CYC)
        else $error("brown-out reset without persistence");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : rsds_top_monitor

bind rsds_top rsds_top_monitor #(.POWERUP_CYC(POWERUP_CYC)) u_mon (
    .clk(clk), .rst_n(rst_n), .por_low(por_low),
    .reset_pin_n(reset_pin_n), .bod_low(bod_low), .core_rst_n(core_rst_n),
    .core_clk_en(core_clk_en), .bod_enable(bod_enable),
    .bod_level_high(bod_level_high), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata));

// ### verif/rsds_supply_model.sv
// Model of supply detectors, reset pin and watchdog oscillator
`timescale 1ns/10ps
module rsds_supply_model (
    // Commands from the bench
    input wire logic por_set,
    input wire logic pin_set,
    input wire logic bod_set,
    // Levels seen by the sequencer
    output logic por_low,
    output logic reset_pin_n,
    output logic bod_low,
    output logic watchdog_oscillator
);
    // Levels follow the commands; detectors add no filtering of their own
    assign por_low = por_set;
    assign reset_pin_n = ~pin_set;
    assign bod_low = bod_set;
    // Free-running slow oscillator, four clocks a period, own phase
    initial
    begin
        watchdog_oscillator = 1'b0;
        #7;
        forever #80 watchdog_oscillator = ~watchdog_oscillator;
    end
endmodule : rsds_supply_model

// ### verif/rsds_top_tb.sv
// Self-checking bench of the reset start-up sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module rsds_top_tb;
    import rsds_pkg::*;
    localparam int PU = 20;
    logic clk = 0, rst_n = 0, por_set = 0, pin_set = 1, bod_set = 0;
    logic sleep_req = 0, wake_req = 0, core_rst_n, core_clk_en, ok;
    logic bod_enable, bod_level_high, por_low, reset_pin_n, bod_low, wdo;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [16:0] lf = 17'h1_8004;
    logic [5:0] fz [5] = '{6'h37, 6'h3F, 6'h3E, 6'h1E, 6'h2C};
    int wdc [5] = '{8, 8, 1024, 4096, 32};
    int ckc [5] = '{6, 1024, 1024, 1024, 16384};
    int miscompares = 0, check_count = 0, cyc = 0, n;
    rsds_supply_model u_sup (.por_set(por_set), .pin_set(pin_set),
        .bod_set(bod_set), .por_low(por_low), .reset_pin_n(reset_pin_n),
        .bod_low(bod_low), .watchdog_oscillator(wdo));
    rsds_top #(.POWERUP_CYC(PU)) dut (.clk(clk), .rst_n(rst_n),
        .por_low(por_low), .reset_pin_n(reset_pin_n), .bod_low(bod_low),
        .watchdog_oscillator(wdo), .sleep_req(sleep_req),
        .wake_req(wake_req), .core_rst_n(core_rst_n),
        .core_clk_en(core_clk_en), .bod_enable(bod_enable),
        .bod_level_high(bod_level_high), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // Clock and hang guard
    initial
        forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            miscompares++;
            final_report();
        end
    end
    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction : lfsr_next
    // Watchdog ticks are four clocks each in this bench
    function automatic int expc(input int wd, input int ck, input int pu);
        return 4 * wd + ck + pu;
    endfunction : expc
    // Slack covers synchronisers and oscillator phase
    function automatic logic in_rng(input int e);
        return n >= e - 4 && n <= e + 16;
    endfunction : in_rng
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Write: address and data offered together, response taken late
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ad && dd))
        begin
            @(posedge clk);
            if (awready === 1'b1) begin ad = 1; awvalid <= 0; end
            if (wready === 1'b1) begin dd = 1; wvalid <= 0; end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1;
        @(posedge clk);
        resp = bresp;
        bready <= 0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1;
        @(posedge clk);
        rd = rdata;
        resp = rresp;
        rready <= 0;
    endtask : axi_rd
    task automatic wait_core(input bit en);
        n = 0;
        do begin @(posedge clk); n++; end
        while ((en ? core_clk_en : core_rst_n) !== 1'b1);
    endtask : wait_core
    task automatic pin_pulse();
        @(posedge clk);
        pin_set <= 1;
        #1 `CHK("pin reset", 1'b0, core_rst_n)
        lf = lfsr_next(lf);
        repeat (2 + lf[1:0]) @(posedge clk);
    endtask : pin_pulse
    // Program fuses while the pin holds reset, then time the release
    task automatic run(input logic [5:0] f, input int e);
        lf = lfsr_next(lf);
        axi_wr(REG_FUSE_OFF, {lf, 9'h0, f});
        axi_rd(REG_FUSE_OFF);
        `CHK("fuse", {26'h0, f}, rd)
        `CHK("bod en", ~f[4], bod_enable)
        `CHK("bod lvl", ~f[5], bod_level_high)
        @(posedge clk);
        pin_set <= 0;
        wait_core(0);
        ok = in_rng(e);
        `CHK("release", 1'b1, ok)
    endtask : run
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        axi_rd(REG_FUSE_OFF);
        `CHK("default", 32'h0000_0032, rd)
        axi_rd(8'h08);
        `CHK("unmapped", RESP_SLVERR, resp)
        `CHK("unmapped data", 32'h0000_0000, rd)
        axi_wr(REG_STATUS_OFF, {15'h0, lf});
        `CHK("status wr", RESP_OKAY, resp)
        for (int i = 0; i < 5; i++)
        begin
            if (i > 0)
                pin_pulse();
            run(fz[i], expc(wdc[i], ckc[i], i == 0 ? PU : 0));
            $display("test select %h done", fz[i]);
        end
        // Short dip, then a real brown-out and recovery
        lf = lfsr_next(lf);
        bod_set <= 1;
        repeat (40 + lf[5:0]) @(posedge clk);
        bod_set <= 0;
        repeat (4) @(posedge clk);
        `CHK("glitch", 1'b1, core_rst_n)
        bod_set <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (core_rst_n !== 1'b0);
        ok = n >= BOD_FILT_LO_CYC && n <= BOD_FILT_LO_CYC + 8;
        `CHK("bod trip", 1'b1, ok)
        bod_set <= 0;
        wait_core(0);
        `CHK("bod release", 1'b1, in_rng(expc(32, 16384, 0)))
        $display("test brown-out done");
        axi_wr(REG_FUSE_OFF, 32'h0000_003F);
        @(posedge clk);
        por_set <= 1;
        #1 `CHK("por", 1'b0, core_rst_n)
        repeat (3) @(posedge clk);
        por_set <= 0;
        wait_core(0);
        `CHK("por release", 1'b1, in_rng(expc(8, 1024, PU)))
        $display("test power-on done");
        pin_pulse();
        run(6'h3E, expc(1024, 1024, 0));
        sleep_req <= 1;
        @(posedge clk);
        sleep_req <= 0;
        repeat (3) @(posedge clk);
        `CHK("sleep", 2'b10, {core_rst_n, core_clk_en})
        wake_req <= 1;
        @(posedge clk);
        wake_req <= 0;
        wait_core(1);
        `CHK("wake", 1'b1, in_rng(1024))
        $display("test wake done");
        final_report();
    end
endmodule : rsds_top_tb
